// >>> hcer_core.sv
// Purpose: Two-wire slave command layer with cause, fault and status reporting
// Assumes: Event inputs and halt_req come from logic on clk; pins are asynchronous
// Notes: Bits are sampled on the bus clock, framing and driving run on clk
//
// Notes on behaviour
// - Device ACKs each byte of a frame whose address it accepts, on the ninth clock; host NACKs last read byte.
// - First byte: seven-bit address in bits 7:1, direction in bit 0.
// - Byte after write-direction address is the command opcode.
// - After read address, device returns the requested data byte.
// - Write is address, opcode, data; opcode D1 carries one pin-enable byte.
// - Bus activity wakes a sleeping device; first address after wake is NACKed.
// - Device may hold the clock low while busy.
// - Cause read D0 returns the cause, clears it and releases alert.
// - Cause bits: 3 error, 2 pin1 edge, 1 pin0 edge, 0 key.
// - One pin enabled sets both pin bits; both enabled sets only its own.
// - Fault read F0 returns the fault byte and clears it.
// - Fault bit 6 queue overflow, bit 4 lost alert; bits 7,5,3 zero.
// - Fault bit 2 too many keys, bit 1 unknown opcode.
// - Fault bit 0 command arrived before device could accept it.
// - Status read E0: 00h after reset, 02h after pin-caused wake.
// - Status 06h after a successful command, 15h after a failed one.
// - Alert goes low on a new event and stays until cause read.
`default_nettype none

module hcer_core import hcer_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = HCER_DEV_ADDR,
  parameter int WAKE_CYC = HCER_WAKE_CYC,
  parameter int STRETCH_CYC = HCER_STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic aux_pin0,
  input wire logic aux_pin1,
  input wire hcer_evt_s evt,
  input wire logic halt_req,
  input wire logic [7:0] ext_rd_data,
  output logic alert_n_q,
  output logic sda_o_q,
  output logic sda_oe_q,
  output logic scl_o_q,
  output logic scl_oe_q,
  output logic [1:0] pin_irq_en_q,
  output hcer_cmd_s cmd_q,
  output logic asleep_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic opc_known(input logic [7:0] op);
    case (op)
      8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42,
      HCER_OPC_CAUSE_RD, HCER_OPC_PIN_EN, HCER_OPC_STAT_RD, 8'hE3, 8'hE4,
      HCER_OPC_FAULT_RD: opc_known = 1'b1;
      default: opc_known = 1'b0;
    endcase
  endfunction

  function automatic logic opc_local_rd(input logic [7:0] op);
    opc_local_rd = (op == HCER_OPC_CAUSE_RD) || (op == HCER_OPC_STAT_RD) || (op == HCER_OPC_FAULT_RD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [HCER_GRAY_W-1:0] link_gray;
  logic link_bit;
  logic [HCER_GRAY_W-1:0] gray_s1_q, gray_s2_q, gray_p_q;
  logic bit_s1_q, bit_s2_q;
  logic bit_ev_q;
  logic [HCER_PIN_N-1:0] pin_s1_q, pin_s2_q, pin_p_q;

  hcer_state_e state_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shreg_q;
  logic [7:0] opcode_q;
  logic [7:0] tx_q;
  logic ack_pend_q;
  logic stretch_arm_q;
  logic sent_q;
  logic [HCER_CNT_W-1:0] stretch_cnt_q;

  logic [7:0] cause_q;
  logic [7:0] fault_q;
  logic [7:0] status_q;
  logic [HCER_CNT_W-1:0] wake_cnt_q;
  logic first_wake_q;

  logic start_c, stop_c, scl_fall;
  logic [7:0] byte_w;
  logic byte_done, addr_hit, not_ready, acc_addr, early_c;
  logic opc_done, wdat_done, tx_ack;
  logic [7:0] tx_sel;
  logic edge0, edge1, pin_edge_any, bus_busy;
  logic [1:0] pin_set;
  logic [7:0] cause_set, fault_set;
  logic cause_clr, fault_clr, lost_c;

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock side
  hcer_link_rx #(
    .GW(HCER_GRAY_W)
  ) u_link_rx (
    .scl_clk(scl_clk),
    .rst_n(rst_n),
    .sda_i(sda_i),
    .bit_gray_q(link_gray),
    .bit_val_q(link_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Crossings and pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gray_s1_q <= '0;
      gray_s2_q <= '0;
      gray_p_q <= '0;
      bit_s1_q <= 1'b1;
      bit_s2_q <= 1'b1;
      bit_ev_q <= 1'b0;
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_p_q <= '1;
    end else begin
      gray_s1_q <= link_gray;
      gray_s2_q <= gray_s1_q;
      gray_p_q <= gray_s2_q;
      bit_s1_q <= link_bit;
      bit_s2_q <= bit_s1_q;
      // Bit value read one cycle after the count moves, so it is surely settled
      bit_ev_q <= (gray_s2_q != gray_p_q);
      pin_s1_q <= {aux_pin1, aux_pin0, sda_i, scl_i};
      pin_s2_q <= pin_s1_q;
      pin_p_q <= pin_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing decode
  always_comb begin
    start_c = pin_s2_q[HCER_PIN_SCL] && pin_p_q[HCER_PIN_SDA] && !pin_s2_q[HCER_PIN_SDA];
    stop_c = pin_s2_q[HCER_PIN_SCL] && !pin_p_q[HCER_PIN_SDA] && pin_s2_q[HCER_PIN_SDA];
    scl_fall = pin_p_q[HCER_PIN_SCL] && !pin_s2_q[HCER_PIN_SCL];
    byte_w = {shreg_q[6:0], bit_s2_q};
    byte_done = bit_ev_q && (bitcnt_q == HCER_BIT_LAST) &&
                (state_q == HCER_ST_ADDR || state_q == HCER_ST_OPC || state_q == HCER_ST_WDATA);
    addr_hit = (state_q == HCER_ST_ADDR) && (byte_w[7:1] == DEV_ADDR);
    not_ready = first_wake_q || (wake_cnt_q != '0) || asleep_q;
    acc_addr = byte_done && addr_hit && !not_ready;
    early_c = byte_done && addr_hit && not_ready;
    opc_done = byte_done && (state_q == HCER_ST_OPC);
    wdat_done = byte_done && (state_q == HCER_ST_WDATA);
    tx_ack = bit_ev_q && (state_q == HCER_ST_TX) && (bitcnt_q == HCER_BIT_ACK);
    case (opcode_q)
      HCER_OPC_CAUSE_RD: tx_sel = cause_q;
      HCER_OPC_FAULT_RD: tx_sel = fault_q;
      HCER_OPC_STAT_RD: tx_sel = status_q;
      default: tx_sel = ext_rd_data;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= HCER_ST_IDLE;
      bitcnt_q <= '0;
      shreg_q <= '0;
      opcode_q <= '0;
      tx_q <= '0;
      ack_pend_q <= 1'b0;
      stretch_arm_q <= 1'b0;
      sent_q <= 1'b0;
    end else begin
      if (bit_ev_q && state_q != HCER_ST_IDLE) begin
        bitcnt_q <= (bitcnt_q == HCER_BIT_ACK) ? 4'h0 : bitcnt_q + 4'h1;
        if (bitcnt_q != HCER_BIT_ACK) begin
          shreg_q <= byte_w;
        end
      end
      if (byte_done) begin
        case (state_q)
          HCER_ST_ADDR: begin
            if (acc_addr) begin
              ack_pend_q <= 1'b1;
              state_q <= byte_w[0] ? HCER_ST_RACK : HCER_ST_OPC;
              stretch_arm_q <= byte_w[0];
              sent_q <= 1'b0;
            end else begin
              state_q <= HCER_ST_WAIT;
            end
          end
          HCER_ST_OPC: begin
            ack_pend_q <= 1'b1;
            opcode_q <= byte_w;
            state_q <= HCER_ST_WDATA;
          end
          default: begin
            ack_pend_q <= 1'b1;
          end
        endcase
      end
      if (bit_ev_q && state_q == HCER_ST_RACK && bitcnt_q == HCER_BIT_ACK) begin
        state_q <= HCER_ST_TX;
        tx_q <= tx_sel;
      end
      if (tx_ack) begin
        sent_q <= 1'b1;
        if (bit_s2_q) begin
          state_q <= HCER_ST_WAIT;
        end else begin
          tx_q <= tx_sel;
        end
      end
      if (scl_fall && !ack_pend_q && state_q == HCER_ST_TX && bitcnt_q != HCER_BIT_ACK) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (scl_fall && ack_pend_q) begin
        ack_pend_q <= 1'b0;
      end
      if (scl_fall && !ack_pend_q && stretch_arm_q && state_q == HCER_ST_TX) begin
        stretch_arm_q <= 1'b0;
      end
      if (start_c) begin
        state_q <= HCER_ST_ADDR;
        bitcnt_q <= '0;
        ack_pend_q <= 1'b0;
        stretch_arm_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= HCER_ST_IDLE;
        bitcnt_q <= '0;
        ack_pend_q <= 1'b0;
        stretch_arm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; changes only while the clock line is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_o_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_o_q <= 1'b0;
      scl_oe_q <= 1'b0;
      stretch_cnt_q <= '0;
    end else begin
      sda_o_q <= 1'b0;
      scl_o_q <= 1'b0;
      if (start_c || stop_c) begin
        sda_oe_q <= 1'b0;
      end else if (scl_fall) begin
        if (ack_pend_q) begin
          sda_oe_q <= 1'b1;
        end else if (state_q == HCER_ST_TX && bitcnt_q != HCER_BIT_ACK) begin
          sda_oe_q <= !tx_q[7];
        end else begin
          sda_oe_q <= 1'b0;
        end
      end
      // Hold the clock after the reply byte is loaded, as its first bit is driven
      if (scl_fall && !ack_pend_q && stretch_arm_q && state_q == HCER_ST_TX) begin
        scl_oe_q <= 1'b1;
        stretch_cnt_q <= HCER_CNT_W'(STRETCH_CYC - 1);
      end else if (scl_oe_q) begin
        if (stretch_cnt_q == '0) begin
          scl_oe_q <= 1'b0;
        end else begin
          stretch_cnt_q <= stretch_cnt_q - 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event sources
  always_comb begin
    edge0 = (pin_s2_q[HCER_PIN_AUX0] ^ pin_p_q[HCER_PIN_AUX0]) && pin_irq_en_q[0];
    edge1 = (pin_s2_q[HCER_PIN_AUX1] ^ pin_p_q[HCER_PIN_AUX1]) && pin_irq_en_q[1];
    pin_edge_any = edge0 || edge1;
    pin_set = (pin_irq_en_q == 2'h3) ? {edge1, edge0} : {2{pin_edge_any}};
    bus_busy = !pin_s2_q[HCER_PIN_SCL] || !pin_s2_q[HCER_PIN_SDA];
    // Cause read cut off before its byte went out
    lost_c = (start_c || stop_c) && (state_q == HCER_ST_RACK || state_q == HCER_ST_TX) &&
             !sent_q && (opcode_q == HCER_OPC_CAUSE_RD);
    fault_set = 8'h00;
    fault_set[HCER_FAULT_QUEUE] = evt.key_event && evt.queue_full;
    fault_set[HCER_FAULT_LOST] = lost_c;
    fault_set[HCER_FAULT_KEYS] = evt.too_many_keys;
    fault_set[HCER_FAULT_UNKNOWN] = opc_done && !opc_known(byte_w);
    fault_set[HCER_FAULT_EARLY] = early_c;
    cause_set = 8'h00;
    cause_set[HCER_CAUSE_KEY] = evt.key_event;
    cause_set[HCER_CAUSE_PIN0] = pin_set[0];
    cause_set[HCER_CAUSE_PIN1] = pin_set[1];
    cause_set[HCER_CAUSE_ERR] = |fault_set;
    cause_clr = tx_ack && (opcode_q == HCER_OPC_CAUSE_RD);
    fault_clr = tx_ack && (opcode_q == HCER_OPC_FAULT_RD);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause, fault and status bytes; a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cause_q <= HCER_CAUSE_RESET;
      fault_q <= HCER_FAULT_RESET;
      status_q <= HCER_STAT_RESET;
    end else begin
      cause_q <= ((cause_clr ? 8'h00 : cause_q) | cause_set) & 8'h0F;
      fault_q <= ((fault_clr ? 8'h00 : fault_q) | fault_set) & 8'h57;
      // Status read reports the command before it, so it never overwrites
      if (opc_done && byte_w != HCER_OPC_STAT_RD) begin
        status_q <= opc_known(byte_w) ? HCER_STAT_OK : HCER_STAT_FAIL;
      end else if (early_c) begin
        status_q <= HCER_STAT_FAIL;
      end else if (asleep_q && pin_edge_any) begin
        status_q <= HCER_STAT_PIN_WAKE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep and wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asleep_q <= 1'b0;
      wake_cnt_q <= '0;
      first_wake_q <= 1'b0;
    end else begin
      if (asleep_q && bus_busy) begin
        asleep_q <= 1'b0;
        first_wake_q <= 1'b1;
        wake_cnt_q <= HCER_CNT_W'(WAKE_CYC);
      end else if (asleep_q && pin_edge_any) begin
        asleep_q <= 1'b0;
      end else if (halt_req && !asleep_q && state_q == HCER_ST_IDLE) begin
        asleep_q <= 1'b1;
      end else if (wake_cnt_q != '0) begin
        wake_cnt_q <= wake_cnt_q - 1'b1;
      end
      // Start byte or NACKed address uses up the post-wake cycle
      if (byte_done && state_q == HCER_ST_ADDR && !asleep_q) begin
        first_wake_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command outputs, pin enables and alert
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q <= '0;
      pin_irq_en_q <= HCER_PIN_EN_RESET;
      alert_n_q <= 1'b1;
    end else begin
      cmd_q.wstrobe <= wdat_done && (opcode_q != HCER_OPC_PIN_EN);
      cmd_q.rd_take <= tx_ack && !opc_local_rd(opcode_q);
      if (opc_done) begin
        cmd_q.opcode <= byte_w;
      end
      if (wdat_done) begin
        cmd_q.wdata <= byte_w;
      end
      if (wdat_done && opcode_q == HCER_OPC_PIN_EN) begin
        pin_irq_en_q <= byte_w[1:0];
      end
      alert_n_q <= !(|cause_q);
    end
  end

endmodule // hcer_core

`default_nettype wire

// >>> hcer_core_sva.sv
// Purpose: Port-level checks of the host command and event report block
// Assumes: Core clock domain only; reset synchronous active low
// Notes: Stretch length checked through a helper counter
`default_nettype none

module hcer_core_sva import hcer_pkg::*; #(
  parameter int STRETCH_CYC = HCER_STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire hcer_evt_s evt,
  input wire logic alert_n_q,
  input wire logic sda_o_q,
  input wire logic sda_oe_q,
  input wire logic scl_o_q,
  input wire logic scl_oe_q,
  input wire logic [1:0] pin_irq_en_q,
  input wire hcer_cmd_s cmd_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [HCER_CNT_W-1:0] stretch_cnt_q;
  logic rd_local;
  assign rd_local = cmd_q.opcode inside {HCER_OPC_CAUSE_RD, HCER_OPC_STAT_RD, HCER_OPC_FAULT_RD};
  always_ff @(posedge clk) begin
    if (!rst_n || !scl_oe_q) stretch_cnt_q <= '0;
    else stretch_cnt_q <= stretch_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_KEY_ALERT: assert property (evt.key_event |-> ##[1:3] !alert_n_q)
    else $error("alert not raised after key event");
  AST_ALERT_RELEASE: assert property ($rose(alert_n_q) |-> cmd_q.opcode == HCER_OPC_CAUSE_RD)
    else $error("alert released without cause read");
  AST_OPEN_DRAIN: assert property (!sda_o_q && !scl_o_q)
    else $error("pin output value not low");
  AST_ACK_SCL_LOW: assert property ($rose(sda_oe_q) |-> !scl_i)
    else $error("data pull started while clock high");
  AST_STRETCH_LEN: assert property ($fell(scl_oe_q) |-> stretch_cnt_q == HCER_CNT_W'(STRETCH_CYC))
    else $error("clock hold length wrong");
  AST_PIN_EN_SRC: assert property ($changed(pin_irq_en_q) |-> cmd_q.opcode == HCER_OPC_PIN_EN)
    else $error("pin enables changed by other opcode");
  AST_WSTROBE: assert property (cmd_q.wstrobe |-> cmd_q.opcode != HCER_OPC_PIN_EN ##1 !cmd_q.wstrobe)
    else $error("write strobe wrong");
  AST_RD_TAKE: assert property (cmd_q.rd_take |-> !rd_local)
    else $error("read take on local opcode");

  COV_STRETCH: cover property ($rose(scl_oe_q));
  COV_ALERT: cover property ($fell(alert_n_q));
  COV_TAKE: cover property (cmd_q.rd_take);
endmodule // hcer_core_sva

bind hcer_core hcer_core_sva #(.STRETCH_CYC(STRETCH_CYC)) i_hcer_core_sva (.clk(clk), .rst_n(rst_n),
  .scl_i(scl_i), .evt(evt), .alert_n_q(alert_n_q), .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q),
  .scl_o_q(scl_o_q), .scl_oe_q(scl_oe_q), .pin_irq_en_q(pin_irq_en_q), .cmd_q(cmd_q));

`default_nettype wire

// >>> hcer_host_bfm.sv
// Purpose: Host bus master model driving the two-wire lines
// Assumes: Pull-up wires resolved outside; 125 ns bit period
// Notes: Clock stands high between frames; lines released when idle
`default_nettype none

module hcer_host_bfm (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_h,
  output logic sda_h
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_h = 1'b1;
    sda_h = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic start_c();
    sda_h = 1'b1;
    #43;
    scl_h = 1'b1;
    #60;
    sda_h = 1'b0;
    #60;
    scl_h = 1'b0;
    #20;
  endtask
  task automatic stop_c();
    sda_h = 1'b0;
    #43;
    scl_h = 1'b1;
    #60;
    sda_h = 1'b1;
    #60;
  endtask
  task automatic bit_c(input logic b, output logic s);
    int stall;
    stall = 0;
    sda_h = b;
    #43;
    scl_h = 1'b1;
    while (scl_w !== 1'b1 && stall < 100) begin
      #10;
      stall++;
    end
    #40;
    s = sda_w;
    #22;
    scl_h = 1'b0;
    #20;
  endtask
  // Idle clocks with the data line high let the link side leave reset
  task automatic idle_clk(input int n);
    repeat (n) begin
      scl_h = 1'b0;
      #62;
      scl_h = 1'b1;
      #63;
    end
  endtask
  // Start byte that nobody acknowledges, only to wake the device
  task automatic wake_byte(output logic ack);
    start_c();
    wr_byte(8'h01, ack);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      d[i] = s;
    end
    bit_c(1'b1, s);
  endtask
  // Host always starts; read turns round with repeated start
  task automatic command(input logic [7:0] wa, input logic [7:0] opc, input logic rd, input logic wd,
    input logic [7:0] wdat, output logic a0, output logic [7:0] rdat);
    logic a;
    rdat = 8'h00;
    start_c();
    wr_byte(wa, a0);
    if (a0) begin
      wr_byte(opc, a);
      if (wd) wr_byte(wdat, a);
      if (rd) begin
        start_c();
        wr_byte(wa | 8'h01, a);
        rd_byte(rdat);
      end
    end
    stop_c();
  endtask
endmodule // hcer_host_bfm

`default_nettype wire

// >>> hcer_link_rx.sv
// Purpose: Bus-clock side capture of each data bit at the clock rising edge
// Assumes: Bus clock stands still between frames; two idle bus clocks follow reset
// Notes: Bit count leaves as gray code; bit value is stable for a whole bus clock period
`default_nettype none

module hcer_link_rx import hcer_pkg::*; #(
  parameter int GW = HCER_GRAY_W
) (
  input wire logic scl_clk,
  input wire logic rst_n,
  input wire logic sda_i,
  output logic [GW-1:0] bit_gray_q,
  output logic bit_val_q
);

  logic rst_s1_q;
  logic rst_s2_q;
  logic [GW-1:0] cnt_q;
  logic [GW-1:0] cnt_d;

  assign cnt_d = cnt_q + 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset brought into the bus clock domain
  always_ff @(posedge scl_clk) begin
    rst_s1_q <= rst_n;
    rst_s2_q <= rst_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One gray step per sampled bit, so only one bit flips per crossing
  always_ff @(posedge scl_clk) begin
    // Unknown reset state falls into the reset branch, so the count settles
    if (rst_s2_q) begin
      cnt_q <= cnt_d;
      bit_gray_q <= cnt_d ^ (cnt_d >> 1);
      bit_val_q <= sda_i;
    end else begin
      cnt_q <= '0;
      bit_gray_q <= '0;
      bit_val_q <= 1'b1;
    end
  end

endmodule // hcer_link_rx

`default_nettype wire

// >>> hcer_pkg.sv
// Purpose: Shared constants and types for the host command and event report block
// Assumes: Core clock of 100 MHz; bus clock pin also feeds the link clock port
// Notes: Named byte codes, bit positions and timing counts live here; the core also hard-codes opcodes and masks
`default_nettype none

package hcer_pkg;

  localparam logic [6:0] HCER_DEV_ADDR = 7'h51;

  localparam logic [7:0] HCER_OPC_CAUSE_RD = 8'hD0;
  localparam logic [7:0] HCER_OPC_PIN_EN = 8'hD1;
  localparam logic [7:0] HCER_OPC_STAT_RD = 8'hE0;
  localparam logic [7:0] HCER_OPC_FAULT_RD = 8'hF0;

  localparam int HCER_CAUSE_KEY = 0;
  localparam int HCER_CAUSE_PIN0 = 1;
  localparam int HCER_CAUSE_PIN1 = 2;
  localparam int HCER_CAUSE_ERR = 3;

  localparam int HCER_FAULT_EARLY = 0;
  localparam int HCER_FAULT_UNKNOWN = 1;
  localparam int HCER_FAULT_KEYS = 2;
  localparam int HCER_FAULT_LOST = 4;
  localparam int HCER_FAULT_QUEUE = 6;

  localparam logic [7:0] HCER_STAT_RESET = 8'h00;
  localparam logic [7:0] HCER_STAT_PIN_WAKE = 8'h02;
  localparam logic [7:0] HCER_STAT_OK = 8'h06;
  localparam logic [7:0] HCER_STAT_FAIL = 8'h15;

  localparam logic [7:0] HCER_CAUSE_RESET = 8'h00;
  localparam logic [7:0] HCER_FAULT_RESET = 8'h00;
  localparam logic [1:0] HCER_PIN_EN_RESET = 2'h0;

  // Pin synchroniser lanes
  localparam int HCER_PIN_SCL = 0;
  localparam int HCER_PIN_SDA = 1;
  localparam int HCER_PIN_AUX0 = 2;
  localparam int HCER_PIN_AUX1 = 3;
  localparam int HCER_PIN_N = 4;

  localparam int HCER_CLK_PERIOD_NS = 10;
  localparam int HCER_WAKE_NS = 2000;
  localparam int HCER_STRETCH_NS = 500;
  localparam int HCER_WAKE_CYC = (HCER_WAKE_NS + HCER_CLK_PERIOD_NS - 1) / HCER_CLK_PERIOD_NS;
  localparam int HCER_STRETCH_CYC = (HCER_STRETCH_NS + HCER_CLK_PERIOD_NS - 1) / HCER_CLK_PERIOD_NS;
  localparam int HCER_CNT_W = 12;

  localparam int HCER_GRAY_W = 3;
  localparam logic [3:0] HCER_BIT_LAST = 4'h7;
  localparam logic [3:0] HCER_BIT_ACK = 4'h8;

  typedef struct packed {
    logic key_event;
    logic queue_full;
    logic too_many_keys;
  } hcer_evt_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] wdata;
    logic wstrobe;
    logic rd_take;
  } hcer_cmd_s;

  typedef enum {
    HCER_ST_IDLE,
    HCER_ST_ADDR,
    HCER_ST_OPC,
    HCER_ST_WDATA,
    HCER_ST_RACK,
    HCER_ST_TX,
    HCER_ST_WAIT
  } hcer_state_e;

endpackage

`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the host command and event report block
// Assumes: Short wake and stretch counts via parameters
// Notes: Host model owns the bus; bench drives events and pins
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hcer_pkg::*;

  logic clk = 1'b0, rst_n = 1'b0, aux0 = 1'b0, aux1 = 1'b0, halt_req = 1'b0;
  hcer_evt_s evt = '0;
  logic [7:0] ext_rd_data = 8'h5A;
  logic scl_h, sda_h, scl_w, sda_w, alert_n_q, sda_o_q, sda_oe_q, scl_o_q, scl_oe_q, asleep_q;
  logic [1:0] pin_irq_en_q;
  hcer_cmd_s cmd_q;
  logic a;
  logic [7:0] d;
  int errors = 0, n_checks = 0;

  assign scl_w = scl_h & ~scl_oe_q;
  assign sda_w = sda_h & ~sda_oe_q;
  always #5 clk = ~clk;

  hcer_core #(.WAKE_CYC(4), .STRETCH_CYC(10)) i_hcer_core (.clk(clk), .rst_n(rst_n), .scl_clk(scl_w),
    .scl_i(scl_w), .sda_i(sda_w), .aux_pin0(aux0), .aux_pin1(aux1), .evt(evt), .halt_req(halt_req),
    .ext_rd_data(ext_rd_data), .alert_n_q(alert_n_q), .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q),
    .scl_o_q(scl_o_q), .scl_oe_q(scl_oe_q), .pin_irq_en_q(pin_irq_en_q), .cmd_q(cmd_q),
    .asleep_q(asleep_q));
  hcer_host_bfm i_hcer_host_bfm (.scl_w(scl_w), .sda_w(sda_w), .scl_h(scl_h), .sda_h(sda_h));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("errors %0d n_checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_cmd(input logic [7:0] opc, input logic [7:0] exp);
    i_hcer_host_bfm.command(8'hA2, opc, 1'b1, 1'b0, 8'h00, a, d);
    chk8(d, exp);
  endtask
  task automatic wr_cmd(input logic [7:0] opc, input logic [7:0] dat);
    i_hcer_host_bfm.command(8'hA2, opc, 1'b0, 1'b1, dat, a, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_cmd(8'hE0, 8'h00);
    chk8({7'h00, alert_n_q}, 8'h01);
    rd_cmd(8'hF0, 8'h00);
  endtask
  task automatic nap();
    cyc(1);
    halt_req = 1'b1;
    cyc(1);
    halt_req = 1'b0;
    cyc(3);
    chk8({7'h00, asleep_q}, 8'h01);
  endtask
  task automatic t_key();
    cyc(1);
    evt.key_event = 1'b1;
    cyc(1);
    evt.key_event = 1'b0;
    cyc(3);
    chk8({7'h00, alert_n_q}, 8'h00);
    rd_cmd(8'hD0, 8'h01);
    cyc(3);
    chk8({7'h00, alert_n_q}, 8'h01);
    rd_cmd(8'hD0, 8'h00);
  endtask
  task automatic t_pins();
    wr_cmd(8'hD1, 8'h01);
    chk8({6'h00, pin_irq_en_q}, 8'h01);
    rd_cmd(8'hE0, 8'h06);
    aux0 = 1'b1; cyc(10);
    rd_cmd(8'hD0, 8'h06);
    wr_cmd(8'hD1, 8'h03);
    aux1 = 1'b1; cyc(10);
    rd_cmd(8'hD0, 8'h04);
  endtask
  task automatic t_faults();
    cyc(1);
    evt = '{key_event: 1'b1, queue_full: 1'b1, too_many_keys: 1'b1};
    cyc(1);
    evt = '0;
    cyc(3);
    rd_cmd(8'hD0, 8'h09);
    rd_cmd(8'hF0, 8'h44);
    rd_cmd(8'hF0, 8'h00);
  endtask
  task automatic t_unknown();
    wr_cmd(8'h55, 8'h3C);
    chk8(cmd_q.opcode, 8'h55);
    chk8(cmd_q.wdata, 8'h3C);
    rd_cmd(8'hE0, 8'h15);
    rd_cmd(8'hF0, 8'h02);
    rd_cmd(8'h20, 8'h5A);
    i_hcer_host_bfm.command(8'hA4, 8'hD1, 1'b0, 1'b1, 8'h00, a, d);
    chk8({7'h00, a}, 8'h00);
  endtask
  task automatic t_sleep();
    nap();
    wr_cmd(8'hD1, 8'h00);
    chk8({7'h00, a}, 8'h00);
    chk8({6'h00, pin_irq_en_q}, 8'h03);
    cyc(20);
    wr_cmd(8'hD1, 8'h00);
    chk8({7'h00, a}, 8'h01);
    chk8({6'h00, pin_irq_en_q}, 8'h00);
    rd_cmd(8'hF0, 8'h01);
    wr_cmd(8'hD1, 8'h01);
    nap();
    aux0 = 1'b0;
    cyc(10);
    chk8({7'h00, asleep_q}, 8'h00);
    rd_cmd(8'hE0, 8'h02);
    nap();
    i_hcer_host_bfm.wake_byte(a);
    chk8({7'h00, a}, 8'h00);
    wr_cmd(8'hD1, 8'h00);
    chk8({7'h00, a}, 8'h01);
    chk8({6'h00, pin_irq_en_q}, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc(10);
    i_hcer_host_bfm.idle_clk(3);
    t_reset();
    t_key();
    t_pins();
    t_faults();
    t_unknown();
    t_sleep();
    complete_run();
  end
  initial begin
    #600000;
    errors++;
    complete_run();
  end
endmodule // tb_top

`default_nettype wire
